/* rtl/gdfr_bank.sv */
// gauge data and flag register bank of the charge-gauging device
// Contract
// - temperature and gauge register at 0x02: code high nibble, gauge low
// - temperature code 0 below -30C, one per 10C band, 12 above 80C
// - temperature code picks efficiency factors and self-discharge rate
// - gauge in sixteenths 0..15 from count, temperature and full reference
// - gauge ratio scaled 1, 0.75, 0.5 by temperature; count untouched
// - 10C hysteresis between unscaled band and 0.75 band
// - count high byte read-write at 0x03, low byte read-only at 0x17
// - count rises on charge, falls on discharge and self-discharge
// - reset clears count, or loads high byte from full count if pin high
// - valid charge detection clears the count low byte
// - pack identifier at 0x04, read-write, no effect on behaviour
// - learned capacity at 0x05, updated by full-to-empty discharge
// - any reset loads learned capacity with programmed full count
// - charge-rate flag bit 7 set on charge start, cleared below 2/s
// - fast factors while charge-rate flag set, trickle otherwise
// - discharge regime bits 6..4: 000 above -150mV, 001 below
// - overload flag bit 0 below -250mV, cleared 0.5s after recovery
// - end-of-discharge sampling stopped in overload, resumed 0.5s after
// - command byte: bit 7 write, low 7 bits address; bad writes ignored
`timescale 1ns/1ns
module gdfr_bank
  import gdfr_pkg::*;
#(
  parameter int unsigned OVERLOAD_FLAG_HOLD_CYC =
    `GDF_OVERLOAD_FLAG_HOLD_MS * 1000 * `GDF_CLK_MHZ,
  parameter int unsigned RATE_WINDOW_CYC =
    `GDF_RATE_WINDOW_MS * 1000 * `GDF_CLK_MHZ
) (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       cmd_valid_in,
  input  wire logic [7:0] command_byte_in,
  input  wire logic [7:0] write_data_in,
  input  wire logic [3:0] temperature_code_in,
  input  wire logic       charge_count_in,
  input  wire logic       discharge_count_in,
  input  wire logic       self_discharge_tick_in,
  input  wire logic       charge_valid_in,
  input  wire logic       sense_below_150_in,
  input  wire logic       sense_below_250_in,
  input  wire logic       empty_detect_in,
  input  wire logic       config_pin_6_in,
  input  wire logic [7:0] programmed_full_count_in,
  input  wire logic       full_ref_is_pfc_in,
  output logic      [7:0] rd_data_out,
  output logic            rd_valid_out,
  output logic      [3:0] gauge_display_out,
  output logic            charge_rate_flag_out,
  output logic            eod_sample_enable_out
);

  gdfr_regs_t s_q;
  gdfr_regs_t s_d;

  always_comb begin
    logic [6:0]  addr;
    logic        is_wr;
    logic        chg_start;
    logic        cold;
    logic [16:0] inc;
    logic [16:0] dfac;
    logic [16:0] sfac;
    logic [17:0] acc;
    logic [7:0]  full;
    logic [11:0] scale;
    logic [11:0] num;
    logic [11:0] quo;
    logic [7:0]  flags;
    logic [7:0]  rd;
    logic [1:0]  hits;

    addr      = command_byte_in[6:0];
    is_wr     = command_byte_in[`GDF_CMD_WRITE_BIT];
    chg_start = s_q.chg_v & ~s_q.chg_v_d;
    // efficiency uses the raw code; only the gauge band has hysteresis
    cold      = s_q.tmp <= `GDF_TMP_BELOW_MINUS10;
    inc       = 17'h00000;
    dfac      = 17'h00000;
    sfac      = 17'h00000;
    acc       = 18'h00000;
    full      = 8'h00;
    scale     = `GDF_SCALE_WARM;
    num       = 12'h000;
    quo       = 12'h000;
    flags     = 8'h00;
    rd        = `GDF_UNMAPPED_READ;
    hits      = 2'h0;

    s_d          = s_q;
    s_d.rd_valid = 1'b0;

    // front-end levels arrive on this clock, so one stage only
    s_d.tmp     = temperature_code_in;
    s_d.chg_p   = charge_count_in;
    s_d.dchg_p  = discharge_count_in;
    s_d.sd_p    = self_discharge_tick_in;
    s_d.chg_v   = charge_valid_in;
    s_d.chg_v_d = s_q.chg_v;
    s_d.b150    = sense_below_150_in;
    s_d.b250    = sense_below_250_in;
    s_d.edv     = empty_detect_in;

    // strap is a real pin, hence three stages
    s_d.p6_s1 = config_pin_6_in;
    s_d.p6_s2 = s_q.p6_s1;
    s_d.p6_s3 = s_q.p6_s2;

    case (s_q.st)
      GDFR_INIT: begin
        // wait for the strap synchroniser to settle before sampling it
        if (s_q.init_cnt != `GDF_INIT_SETTLE) begin
          s_d.init_cnt = s_q.init_cnt + 2'h1;
        end else if (s_q.p6_s2 == s_q.p6_s3) begin
          // a strap caught mid-change holds init until both stages agree
          s_d.st       = GDFR_RUN;
          s_d.init_cnt = 2'h0;
          if (s_q.p6_s3) begin
            s_d.nominal_charge_count = {programmed_full_count_in, 8'h00};
          end else begin
            s_d.nominal_charge_count = 16'h0000;
          end
          s_d.learned_full_capacity = programmed_full_count_in;
        end
      end

      GDFR_RUN: begin
        // gauge correction band with hysteresis on the warm edge
        case (s_q.band)
          GDFR_WARM: begin
            if (s_q.tmp <= `GDF_TMP_BELOW_MINUS20) begin
              s_d.band = GDFR_COLD;
            end else if (s_q.tmp <= `GDF_TMP_BELOW_MINUS10) begin
              s_d.band = GDFR_COOL;
            end
          end
          GDFR_COOL: begin
            if (s_q.tmp >= `GDF_TMP_ABOVE_ZERO) begin
              s_d.band = GDFR_WARM;
            end else if (s_q.tmp <= `GDF_TMP_BELOW_MINUS20) begin
              s_d.band = GDFR_COLD;
            end
          end
          GDFR_COLD: begin
            if (s_q.tmp >= `GDF_TMP_ABOVE_MINUS20) begin
              s_d.band = GDFR_COOL;
            end
          end
          default: begin
            s_d.band = GDFR_WARM;
          end
        endcase

        // efficiency and self-discharge from temperature and charge rate
        if (s_q.cr) begin
          inc = cold ? `GDF_EFF_FAST_COLD : `GDF_EFF_FAST;
        end else begin
          inc = cold ? `GDF_EFF_TRICKLE_COLD : `GDF_EFF_TRICKLE;
        end
        dfac = cold ? `GDF_DIS_COLD : `GDF_DIS_WARM;
        sfac = `GDF_SELF_DIS_BASE + {13'h0000, s_q.tmp};

        // count moves in 1/256 steps; the low byte is the fraction
        acc = {2'b00, s_q.nominal_charge_count};
        if (s_q.chg_p) begin
          acc = acc + {1'b0, inc};
        end
        if (s_q.dchg_p) begin
          acc = acc - {1'b0, dfac};
        end
        if (s_q.sd_p) begin
          acc = acc - {1'b0, sfac};
        end
        // saturate instead of wrapping at either end
        if (acc[17]) begin
          s_d.nominal_charge_count = 16'h0000;
        end else if (acc[16]) begin
          s_d.nominal_charge_count = 16'hFFFF;
        end else begin
          s_d.nominal_charge_count = acc[15:0];
        end
        if (chg_start) begin
          s_d.nominal_charge_count[7:0] = 8'h00;
        end

        // charge-rate flag and its one-window rate check
        if (chg_start) begin
          s_d.cr        = 1'b1;
          s_d.rate_cnt  = '0;
          s_d.rate_hits = 2'h0;
        end else if (s_q.cr) begin
          s_d.rate_cnt = s_q.rate_cnt + 1'b1;
          hits         = s_q.rate_hits;
          // hits saturate at the threshold; more pulses add nothing
          if (s_q.chg_p && s_q.rate_hits != `GDF_RATE_MIN_COUNTS) begin
            hits = s_q.rate_hits + 2'h1;
          end
          s_d.rate_hits = hits;
          if (s_q.rate_cnt ==
              `GDF_TIMER_W'(RATE_WINDOW_CYC - 1)) begin
            // a pulse on the window's last cycle still counts for it
            s_d.rate_cnt  = '0;
            s_d.rate_hits = 2'h0;
            if (hits < `GDF_RATE_MIN_COUNTS) begin
              s_d.cr = 1'b0;
            end
          end
        end

        // overload and end-of-discharge sampling hold-off share a timer
        // while below -250 mV the hold-off restarts every cycle
        if (s_q.b250) begin
          s_d.overload_flag     = 1'b1;
          s_d.samp_en  = 1'b0;
          s_d.overload_flag_cnt = '0;
        end else if (s_q.overload_flag || !s_q.samp_en) begin
          s_d.overload_flag_cnt = s_q.overload_flag_cnt + 1'b1;
          if (s_q.overload_flag_cnt ==
              `GDF_TIMER_W'(OVERLOAD_FLAG_HOLD_CYC - 1)) begin
            s_d.overload_flag     = 1'b0;
            s_d.samp_en  = 1'b1;
            s_d.overload_flag_cnt = '0;
          end
        end

        // capacity learning from a full-to-empty discharge
        // any charge start voids a learning run in progress
        if (chg_start) begin
          s_d.learn_act = 1'b0;
        end else if (!s_q.learn_act) begin
          if (s_q.dchg_p && s_q.nominal_charge_count[15:8] == s_q.learned_full_capacity) begin
            s_d.learn_act = 1'b1;
            s_d.learn_cnt = dfac[15:0];
          end
        end else begin
          if (s_q.dchg_p) begin
            s_d.learn_cnt = s_q.learn_cnt + dfac[15:0];
          end
          // empty is only believed while sampling is enabled
          if (s_q.edv && s_q.samp_en) begin
            s_d.learn_act = 1'b0;
            if (s_q.learn_cnt[15:8] != 8'h00) begin
              s_d.learned_full_capacity = s_q.learn_cnt[15:8];
            end
          end
        end

        // gauge from scaled count over the chosen full reference
        full = full_ref_is_pfc_in ? programmed_full_count_in : s_q.learned_full_capacity;
        case (s_q.band)
          GDFR_COOL: scale = `GDF_SCALE_COOL;
          GDFR_COLD: scale = `GDF_SCALE_COLD;
          default:   scale = `GDF_SCALE_WARM;
        endcase
        // count*16*scale/(4*full) in sixteenths, never above 255*16
        num = {4'h0, s_q.nominal_charge_count[15:8]} * scale * 12'h004;
        if (full == 8'h00) begin
          s_d.gauge = (num == 12'h000) ? 4'h0 : `GDF_GAUGE_MAX;
        end else begin
          quo = num / {4'h0, full};
          s_d.gauge = (quo > 12'(`GDF_GAUGE_MAX)) ?
                      `GDF_GAUGE_MAX : quo[3:0];
        end

        // host access; unlisted or read-only addresses drop writes
        if (cmd_valid_in && is_wr) begin
          case (addr)
            `GDF_ADDR_COUNT_HIGH: begin
              // host must keep this at or under the learned capacity
              s_d.nominal_charge_count[15:8] = write_data_in;
            end
            `GDF_ADDR_PACK_ID: begin
              s_d.pack_id = write_data_in;
            end
            `GDF_ADDR_FULL_CAP: begin
              s_d.learned_full_capacity = write_data_in;
            end
            `GDF_ADDR_SOFT_RESET: begin
              // overload timer and pack identifier survive this reset
              if (write_data_in == `GDF_SOFT_RESET_VALUE) begin
                s_d.st        = GDFR_INIT;
                s_d.init_cnt  = 2'h0;
                s_d.cr        = 1'b0;
                s_d.learn_act = 1'b0;
              end
            end
            default: begin
              s_d.st = s_q.st;
            end
          endcase
        end
      end

      default: begin
        s_d.st = GDFR_INIT;
      end
    endcase

    // reads answer in any state, one cycle after the command
    flags = 8'h00;
    flags[`GDF_FLG_CHARGE_RATE] = s_q.cr;
    if (s_q.b150) begin
      flags[`GDF_FLG_REGIME_LSB +: 3] = `GDF_REGIME_HEAVY;
    end else begin
      flags[`GDF_FLG_REGIME_LSB +: 3] = `GDF_REGIME_LIGHT;
    end
    flags[`GDF_FLG_OVERLOAD] = s_q.overload_flag;
    case (addr)
      `GDF_ADDR_TEMP_GAUGE: rd = {s_q.tmp, s_q.gauge};
      `GDF_ADDR_COUNT_HIGH: rd = s_q.nominal_charge_count[15:8];
      `GDF_ADDR_PACK_ID:    rd = s_q.pack_id;
      `GDF_ADDR_FULL_CAP:   rd = s_q.learned_full_capacity;
      `GDF_ADDR_SEC_FLAGS:  rd = flags;
      `GDF_ADDR_COUNT_LOW:  rd = s_q.nominal_charge_count[7:0];
      default:              rd = `GDF_UNMAPPED_READ;
    endcase
    if (cmd_valid_in && !is_wr) begin
      s_d.rd_data  = rd;
      s_d.rd_valid = 1'b1;
    end
  end

  // pack identifier has no meaningful reset; zero only keeps sim defined
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s_q         <= '0;
      s_q.st      <= GDFR_INIT;
      s_q.band    <= GDFR_WARM;
      // sampling is allowed until an overload is seen
      s_q.samp_en <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rd_data_out           = s_q.rd_data;
  assign rd_valid_out          = s_q.rd_valid;
  assign gauge_display_out     = s_q.gauge;
  assign charge_rate_flag_out  = s_q.cr;
  assign eod_sample_enable_out = s_q.samp_en;

endmodule : gdfr_bank

/* rtl/gdfr_defs.svh */
// offsets, field positions, reset values and timing counts of the gauge regs
`ifndef GDFR_DEFS_SVH
`define GDFR_DEFS_SVH

// register addresses, 7-bit
`define GDF_ADDR_TEMP_GAUGE   7'h02
`define GDF_ADDR_COUNT_HIGH   7'h03
`define GDF_ADDR_PACK_ID      7'h04
`define GDF_ADDR_FULL_CAP     7'h05
`define GDF_ADDR_SEC_FLAGS    7'h06
`define GDF_ADDR_COUNT_LOW    7'h17
`define GDF_ADDR_SOFT_RESET   7'h39

// command byte fields
`define GDF_CMD_WRITE_BIT     7
`define GDF_SOFT_RESET_VALUE  8'h80

// secondary flag fields
`define GDF_FLG_CHARGE_RATE   7
`define GDF_FLG_REGIME_LSB    4
`define GDF_FLG_OVERLOAD      0
`define GDF_REGIME_LIGHT      3'h0
`define GDF_REGIME_HEAVY      3'h1
`define GDF_UNMAPPED_READ     8'h00

// temperature codes bounding the gauge correction bands
`define GDF_TMP_ABOVE_ZERO    4'h4
`define GDF_TMP_BELOW_MINUS10 4'h2
`define GDF_TMP_BELOW_MINUS20 4'h1
`define GDF_TMP_ABOVE_MINUS20 4'h2
`define GDF_GAUGE_MAX         4'hF

// gauge multipliers in quarters
`define GDF_SCALE_WARM        12'h004
`define GDF_SCALE_COOL        12'h003
`define GDF_SCALE_COLD        12'h002

// efficiency factors, in 1/256 of a high-byte count
`define GDF_EFF_FAST          17'h000F0
`define GDF_EFF_FAST_COLD     17'h000C0
`define GDF_EFF_TRICKLE       17'h000C0
`define GDF_EFF_TRICKLE_COLD  17'h00080
`define GDF_DIS_WARM          17'h00100
`define GDF_DIS_COLD          17'h00110
`define GDF_SELF_DIS_BASE     17'h00001
`define GDF_RATE_MIN_COUNTS   2'h2

// timing
`define GDF_CLK_MHZ           100
`define GDF_OVERLOAD_FLAG_HOLD_MS      500
`define GDF_RATE_WINDOW_MS    1000
`define GDF_TIMER_W           27
`define GDF_INIT_SETTLE       2'h3

`endif

/* rtl/gdfr_pkg.sv */
// types shared by the gauge data and flag register bank
package gdfr_pkg;
  `include "gdfr_defs.svh"

  typedef enum logic [0:0] {GDFR_INIT, GDFR_RUN} gdfr_state_t;

  typedef enum logic [1:0] {GDFR_WARM, GDFR_COOL, GDFR_COLD} gdfr_band_t;

  typedef struct packed {
    gdfr_state_t              st;
    logic [1:0]               init_cnt;
    logic                     p6_s1;
    logic                     p6_s2;
    logic                     p6_s3;
    logic [3:0]               tmp;
    logic                     chg_p;
    logic                     dchg_p;
    logic                     sd_p;
    logic                     chg_v;
    logic                     chg_v_d;
    logic                     b150;
    logic                     b250;
    logic                     edv;
    logic [15:0]              nominal_charge_count;
    logic [7:0]               learned_full_capacity;
    logic [7:0]               pack_id;
    gdfr_band_t               band;
    logic [3:0]               gauge;
    logic                     cr;
    logic [`GDF_TIMER_W-1:0]  rate_cnt;
    logic [1:0]               rate_hits;
    logic                     overload_flag;
    logic [`GDF_TIMER_W-1:0]  overload_flag_cnt;
    logic                     samp_en;
    logic                     learn_act;
    logic [15:0]              learn_cnt;
    logic [7:0]               rd_data;
    logic                     rd_valid;
  } gdfr_regs_t;
endpackage : gdfr_pkg

/* tb/gdfr_bank_chk.sv */
// port assertions for the gauge data and flag register bank
`timescale 1ns/1ns
module gdfr_bank_chk #(
  parameter int unsigned OVERLOAD_FLAG_HOLD_CYC = 20
) (
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       cmd_valid_in,
  input wire logic [7:0] command_byte_in,
  input wire logic [3:0] temperature_code_in,
  input wire logic       charge_valid_in,
  input wire logic       sense_below_150_in,
  input wire logic       sense_below_250_in,
  input wire logic [7:0] rd_data_out,
  input wire logic       rd_valid_out,
  input wire logic       charge_rate_flag_out,
  input wire logic       eod_sample_enable_out
);
  logic [31:0] calm_q;
  logic [31:0] calm_d;
  logic        rd_cmd;
  logic [6:0]  adr;
  assign rd_cmd = cmd_valid_in && !command_byte_in[7];
  assign adr = command_byte_in[6:0];
  // cycles since overload input last seen high; saturates so reset reads as calm
  always_comb begin
    calm_d = calm_q;
    if (sense_below_250_in) calm_d = 32'h0;
    else if (calm_q != 32'hFFFFFFFF) calm_d = calm_q + 32'h1;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) calm_q <= 32'hFFFFFFFF;
    else calm_q <= calm_d;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_read_answer: assert property (rd_cmd |=> rd_valid_out)
    else $error("read not answered");
  a_no_stray: assert property (!rd_cmd |=> !rd_valid_out)
    else $error("stray read valid");
  a_rd_hold: assert property (!rd_cmd |=> $stable(rd_data_out))
    else $error("read data moved");
  a_unmapped_zero: assert property (rd_cmd && !(adr inside {7'h02,
    7'h03, 7'h04, 7'h05, 7'h06, 7'h17}) |=> rd_data_out == 8'h00)
    else $error("unmapped read not zero");
  a_temp_field: assert property (rd_cmd && adr == 7'h02 &&
    $stable(temperature_code_in) && $past($stable(temperature_code_in))
    |=> rd_data_out[7:4] == $past(temperature_code_in))
    else $error("temperature field wrong");
  a_regime_bits: assert property (rd_cmd && adr == 7'h06 &&
    $stable(sense_below_150_in) && $past($stable(sense_below_150_in))
    |=> rd_data_out[6:1] == {2'h0, $past(sense_below_150_in), 3'h0})
    else $error("regime bits wrong");
  a_overload_flag_stop: assert property ($rose(sense_below_250_in)
    |-> ##3 !eod_sample_enable_out)
    else $error("sampling not stopped");
  a_eod_held: assert property (calm_q > 0 &&
    calm_q < OVERLOAD_FLAG_HOLD_CYC |-> !eod_sample_enable_out)
    else $error("sampling resumed early");
  a_eod_resume: assert property (calm_q >= OVERLOAD_FLAG_HOLD_CYC + 5
    |-> eod_sample_enable_out)
    else $error("sampling not resumed");
  a_cr_start: assert property ($rose(charge_valid_in)
    |-> ##3 charge_rate_flag_out)
    else $error("charge rate flag not set");
endmodule : gdfr_bank_chk
bind gdfr_bank gdfr_bank_chk #(.OVERLOAD_FLAG_HOLD_CYC(OVERLOAD_FLAG_HOLD_CYC)) u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_valid_in),
  .command_byte_in(command_byte_in),
  .temperature_code_in(temperature_code_in),
  .charge_valid_in(charge_valid_in), .sense_below_150_in(sense_below_150_in),
  .sense_below_250_in(sense_below_250_in), .rd_data_out(rd_data_out),
  .rd_valid_out(rd_valid_out), .charge_rate_flag_out(charge_rate_flag_out),
  .eod_sample_enable_out(eod_sample_enable_out)
);

/* tb/gdfr_host.sv */
// host processor model issuing register commands
`timescale 1ns/1ns
module gdfr_host (
  input  wire logic       clk_in,
  input  wire logic [7:0] rd_data_in,
  input  wire logic       rd_valid_in,
  output logic            cmd_valid_out,
  output logic      [7:0] command_byte_out,
  output logic      [7:0] write_data_out
);
  initial begin
    cmd_valid_out = 1'b0;
    command_byte_out = 8'h00;
    write_data_out = 8'h00;
  end
  task automatic issue(input logic [7:0] cmd, input logic [7:0] wd);
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b1;
    command_byte_out = cmd;
    write_data_out = wd;
    @(posedge clk_in);
    #1;
    cmd_valid_out = 1'b0;
    // idle lines carry inverted junk so stale values cannot pass
    command_byte_out = ~cmd;
    write_data_out = ~wd;
  endtask : issue
  task automatic rd(input logic [6:0] a, output logic [7:0] d,
                    output logic ok);
    issue({1'b0, a}, 8'h00);
    ok = rd_valid_in;
    d = rd_data_in;
  endtask : rd
endmodule : gdfr_host

/* tb/gdfr_bank_bench.sv */
// self-checking bench for the gauge data and flag register bank
`timescale 1ns/1ns
module gdfr_bank_bench;
  localparam int unsigned HOLD = 20;
  localparam int unsigned WIN = 40;
  localparam logic [7:0] PROGRAMMED_FULL_COUNT = 8'h40;
  localparam logic [3:0] TC [7] = '{4'h4, 4'h3, 4'h2, 4'h3, 4'h1, 4'h4, 4'hC};
  localparam logic [3:0] GG [7] = '{4'h8, 4'h8, 4'h6, 4'h6, 4'h4, 4'h8, 4'h8};
  logic       clk_in, rst_in, chg, dis, sdis, cval, b150, b250, strap;
  logic       pref, empty, cmd_v, rvalid, cr, eod;
  logic [3:0] temp, disp;
  logic [7:0] cmd, wd, rdata;
  int         n_mismatch, n_checks;
  gdfr_host u_gdfr_host (.clk_in(clk_in), .rd_data_in(rdata),
    .rd_valid_in(rvalid), .cmd_valid_out(cmd_v), .command_byte_out(cmd),
    .write_data_out(wd));
  gdfr_bank #(.OVERLOAD_FLAG_HOLD_CYC(HOLD), .RATE_WINDOW_CYC(WIN)) u_gdfr_bank (
    .clk_in(clk_in), .rst_in(rst_in), .cmd_valid_in(cmd_v),
    .command_byte_in(cmd), .write_data_in(wd), .temperature_code_in(temp),
    .charge_count_in(chg), .discharge_count_in(dis),
    .self_discharge_tick_in(sdis), .charge_valid_in(cval),
    .sense_below_150_in(b150), .sense_below_250_in(b250),
    .empty_detect_in(empty), .config_pin_6_in(strap),
    .programmed_full_count_in(PROGRAMMED_FULL_COUNT), .full_ref_is_pfc_in(pref),
    .rd_data_out(rdata), .rd_valid_out(rvalid), .gauge_display_out(disp),
    .charge_rate_flag_out(cr), .eod_sample_enable_out(eod));
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : cyc
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_gdfr_host.rd(a, d, ok);
    check({7'h0, ok}, 8'h01);
    check(d, exp);
  endtask : rd_chk
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_gdfr_host.issue({1'b1, a}, d);
  endtask : wr
  // kind 0 charge, 1 discharge, 2 self-discharge
  task automatic pulses(input int n, input int k);
    repeat (n) begin
      chg = (k == 0);
      dis = (k == 1);
      sdis = (k == 2);
      cyc(1);
    end
    chg = 0;
    dis = 0;
    sdis = 0;
    cyc(3);
  endtask : pulses
  task automatic t_reset_values();
    rd_chk(7'h03, 8'h00);
    rd_chk(7'h17, 8'h00);
    rd_chk(7'h05, PROGRAMMED_FULL_COUNT);
    rd_chk(7'h06, 8'h00);
    rd_chk(7'h10, 8'h00);
  endtask : t_reset_values
  task automatic t_writes();
    wr(7'h04, 8'h5A);
    rd_chk(7'h04, 8'h5A);
    wr(7'h05, 8'h30);
    rd_chk(7'h05, 8'h30);
    wr(7'h03, 8'h18);
    rd_chk(7'h03, 8'h18);
    wr(7'h17, 8'hFF);
    rd_chk(7'h17, 8'h00);
    wr(7'h02, 8'hFF);
    wr(7'h06, 8'hFF);
    wr(7'h10, 8'hFF);
    rd_chk(7'h06, 8'h00);
    rd_chk(7'h10, 8'h00);
  endtask : t_writes
  task automatic t_gauge();
    for (int i = 0; i < 7; i++) begin
      temp = TC[i];
      cyc(6);
      rd_chk(7'h02, {TC[i], GG[i]});
      check({4'h0, disp}, {4'h0, GG[i]});
    end
    pref = 1;
    cyc(4);
    rd_chk(7'h02, 8'hC6);
    pref = 0;
    temp = 4'h4;
    cyc(6);
  endtask : t_gauge
  task automatic t_flags();
    b150 = 1;
    cyc(4);
    rd_chk(7'h06, 8'h10);
    b250 = 1;
    cyc(4);
    rd_chk(7'h06, 8'h11);
    check({7'h0, eod}, 8'h00);
    b150 = 0;
    b250 = 0;
    cyc(HOLD / 2);
    rd_chk(7'h06, 8'h01);
    cyc(HOLD);
    rd_chk(7'h06, 8'h00);
    check({7'h0, eod}, 8'h01);
  endtask : t_flags
  task automatic t_counting();
    int i;
    pulses(1, 2);
    rd_chk(7'h03, 8'h17);
    rd_chk(7'h17, 8'hFB);
    cval = 1;
    cyc(4);
    check({7'h0, cr}, 8'h01);
    rd_chk(7'h17, 8'h00);
    pulses(16, 0);
    rd_chk(7'h03, 8'h26);
    for (i = 0; i < 4 * WIN && cr !== 1'b0; i++) cyc(1);
    if (i == 4 * WIN) begin
      n_mismatch++;
      give_verdict();
    end
    pulses(4, 0);
    rd_chk(7'h03, 8'h29);
    cval = 0;
    pulses(2, 1);
    rd_chk(7'h03, 8'h27);
  endtask : t_counting
  task automatic t_soft_reset();
    strap = 1;
    cyc(4);
    wr(7'h39, 8'h80);
    cyc(8);
    rd_chk(7'h03, PROGRAMMED_FULL_COUNT);
    rd_chk(7'h05, PROGRAMMED_FULL_COUNT);
    rd_chk(7'h04, 8'h5A);
  endtask : t_soft_reset
  // full-to-empty learning from count = capacity, then cold factors
  task automatic t_learn();
    pulses(3, 1);
    empty = 1;
    cyc(1);
    empty = 0;
    cyc(3);
    rd_chk(7'h05, 8'h03);
    rd_chk(7'h03, 8'h3D);
    temp = 4'h2;
    cyc(3);
    pulses(2, 1);
    rd_chk(7'h03, 8'h3A);
    rd_chk(7'h17, 8'hE0);
    pulses(2, 0);
    rd_chk(7'h03, 8'h3B);
  endtask : t_learn
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    {chg, dis, sdis, cval, b150, b250, strap, pref, empty} = 9'h000;
    rst_in = 1;
    temp = 4'h4;
    n_mismatch = 0;
    n_checks = 0;
    repeat (5) @(posedge clk_in);
    #1;
    rst_in = 0;
    cyc(8);
    t_reset_values();
    t_writes();
    t_gauge();
    t_flags();
    t_counting();
    t_soft_reset();
    t_learn();
    give_verdict();
  end
endmodule : gdfr_bank_bench
